// ### ssi_pkg.sv
// Package with register map, field positions, codes and reset values for the self-test indicator.
package ssi_pkg;
	// Node address map.
	localparam logic [31:0] NODE1_BASE = 32'he188_0000;
	localparam logic [31:0] NODE_STRIDE = 32'h0008_0000;
	localparam logic [3:0] NODE_MIN = 4'h1;
	localparam logic [3:0] NODE_MAX = 4'he;
	// Register offsets from the node base.
	localparam logic [18:0] OFF_BUS_ERROR_STATUS = 19'h00004;
	localparam logic [18:0] OFF_GENERAL_SCRATCH = 19'h0000c;
	localparam logic [18:0] OFF_PROCESSOR_CONTROL_ZERO = 19'h00024;
	// Field positions.
	localparam int BIT_ERR_SUMMARY = 31;
	localparam int BIT_ONBOARD_FAIL = 10;
	localparam int BIT_LED_SEL_HI = 14;
	localparam int BIT_LED_SEL_LO = 13;
	localparam int BIT_BCACHE_OFF = 0;
	localparam int CODE_MSB = 31;
	localparam int CODE_LSB = 24;
	// Error indicator selection codes.
	localparam logic [1:0] SEL_SUMMARY = 2'h0;
	localparam logic [1:0] SEL_BCACHE = 2'h1;
	localparam logic [1:0] SEL_EITHER = 2'h2;
	localparam logic [1:0] SEL_NEVER = 2'h3;
	// Failing test groups, as reported by the self-test sequence.
	localparam logic [2:0] GRP_SELFTEST = 3'h0;
	localparam logic [2:0] GRP_INTERACT = 3'h1;
	localparam logic [2:0] GRP_MEMORY = 3'h2;
	localparam logic [2:0] GRP_MULTI = 3'h3;
	localparam logic [2:0] GRP_ADAPTER = 3'h4;
	// Binary code offsets and ranges.
	localparam logic [7:0] OFFS_INTERACT = 8'h3c;
	localparam logic [7:0] OFFS_MULTI = 8'h5a;
	localparam logic [7:0] MEM_CODE_BASE = 8'h53;
	localparam logic [7:0] MEM_FIRST = 8'h02;
	localparam logic [7:0] MEM_LAST = 8'h08;
	localparam logic [7:0] SCALAR_LAST = 8'h2d;
	localparam logic [7:0] VECTOR_FIRST = 8'h2e;
	localparam logic [7:0] VECTOR_LAST = 8'h39;
	localparam logic [7:0] ADAPTER_LAST = 8'h30;
	localparam logic [7:0] CODE_MAX = 8'h63;
	// Reset values.
	localparam logic [31:0] RST_BUS_ERROR_STATUS = 32'h0000_0000;
	localparam logic [31:0] RST_GENERAL_SCRATCH = 32'h0000_0000;
	localparam logic [31:0] RST_PROCESSOR_CONTROL_ZERO = 32'h0000_0000;
	// Top two red indicators lit, the other six red indicators dark.
	localparam logic [7:0] PASS_PATTERN = 8'hc0;
	// Sequencer states.
	typedef enum logic [1:0]
	{
		ST_RUN = 2'b00,
		ST_PASS = 2'b01,
		ST_FAIL = 2'b10
	} ssi_state_t;
endpackage

// ### ssi_selftest_status_indicator.sv
// Self-test status indicator: LEDs, failing-test code and status registers of one processor node.
module ssi_selftest_status_indicator
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Node identity and role.
	input wire logic [3:0] node_id,
	input wire logic boot_proc,
	// Self-test sequence report, one-cycle pulses from the test engine.
	input wire logic test_done,
	input wire logic test_fail,
	input wire logic [2:0] fail_group,
	input wire logic [7:0] fail_number,
	// Error sources.
	input wire logic error_summary_in,
	// Register port.
	input wire logic [31:0] reg_addr,
	input wire logic reg_rd,
	input wire logic reg_wr,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	output logic reg_hit,
	// Indicators, red index 7 is the top one.
	output logic led_yellow,
	output logic [7:0] led_red,
	output logic led_role,
	output logic led_error
);
	ssi_pkg::ssi_state_t state, next_state;
	logic [31:0] bus_error_status, next_bus_error_status;
	logic [31:0] general_scratch, next_general_scratch;
	logic [31:0] processor_control_zero, next_processor_control_zero;
	logic powerup, next_powerup;
	logic [7:0] code, next_code;
	logic next_yellow;
	logic [7:0] next_red;
	logic next_role;
	logic next_error;
	logic [31:0] next_rdata;
	logic next_hit;
	logic [31:0] base;
	logic [18:0] off;
	logic in_node;
	logic [7:0] bin_code;
	logic [7:0] bcd_code;
	logic [7:0] mem_index;
	logic shows_here;
	logic [1:0] sel;
	logic bcache_off;
	logic [2:0] fail_group_q, next_fail_group_q;

	// Node base decode; only the high 13 bits choose the node window.
	always_comb
	begin
		base = ssi_pkg::NODE1_BASE + (32'(node_id - ssi_pkg::NODE_MIN) << 19);
		off = reg_addr[18:0];
		in_node = (reg_addr[31:19] == base[31:19]) && (node_id >= ssi_pkg::NODE_MIN)
			&& (node_id <= ssi_pkg::NODE_MAX);
	end

	// Binary failing code per group, then BCD conversion.
	always_comb
	begin
		mem_index = fail_number - ssi_pkg::MEM_FIRST;
		case (fail_group)
			ssi_pkg::GRP_SELFTEST: bin_code = fail_number;
			ssi_pkg::GRP_INTERACT: bin_code = fail_number + ssi_pkg::OFFS_INTERACT;
			ssi_pkg::GRP_MEMORY: bin_code = ssi_pkg::MEM_CODE_BASE + mem_index;
			ssi_pkg::GRP_MULTI: bin_code = fail_number + ssi_pkg::OFFS_MULTI;
			ssi_pkg::GRP_ADAPTER: bin_code = fail_number;
			default: bin_code = fail_number;
		endcase
		if (bin_code > ssi_pkg::CODE_MAX)
		begin
			bin_code = ssi_pkg::CODE_MAX;
		end
		bcd_code = {4'(bin_code / 8'h0a), 4'(bin_code % 8'h0a)};
		// Adapter failures are only shown by the boot processor.
		shows_here = (fail_group != ssi_pkg::GRP_ADAPTER) || boot_proc;
	end

	// Sequencer and register next values.
	always_comb
	begin
		next_state = state;
		next_bus_error_status = bus_error_status;
		next_general_scratch = general_scratch;
		next_processor_control_zero = processor_control_zero;
		next_powerup = powerup;
		next_code = code;
		// Power-up meaning of the error LED ends with the first control write.
		if (reg_wr && in_node && off == ssi_pkg::OFF_PROCESSOR_CONTROL_ZERO)
		begin
			next_processor_control_zero = reg_wdata;
			next_powerup = 1'b0;
		end
		if (reg_wr && in_node && off == ssi_pkg::OFF_GENERAL_SCRATCH)
		begin
			next_general_scratch = reg_wdata;
		end
		// Software may write the status; the failure record and the summary bit come after
		// it, so a hardware set in the same cycle wins.
		if (reg_wr && in_node && off == ssi_pkg::OFF_BUS_ERROR_STATUS)
		begin
			next_bus_error_status = reg_wdata;
		end
		case (state)
			ssi_pkg::ST_RUN:
			begin
				if (test_fail && shows_here)
				begin
					next_state = ssi_pkg::ST_FAIL;
					next_code = bcd_code;
					next_general_scratch[ssi_pkg::CODE_MSB:ssi_pkg::CODE_LSB] = bcd_code;
					next_bus_error_status[ssi_pkg::BIT_ONBOARD_FAIL] =
						(fail_group == ssi_pkg::GRP_SELFTEST);
				end
				else if (test_done)
				begin
					next_state = ssi_pkg::ST_PASS;
				end
			end
			ssi_pkg::ST_PASS, ssi_pkg::ST_FAIL:
			begin
				next_state = state;
			end
			default: next_state = ssi_pkg::ST_RUN;
		endcase
		if (error_summary_in)
		begin
			next_bus_error_status[ssi_pkg::BIT_ERR_SUMMARY] = 1'b1;
		end
	end

	// Indicator and read-data next values.
	always_comb
	begin
		sel = processor_control_zero[ssi_pkg::BIT_LED_SEL_HI:ssi_pkg::BIT_LED_SEL_LO];
		bcache_off = processor_control_zero[ssi_pkg::BIT_BCACHE_OFF];
		next_yellow = 1'b0;
		next_red = 8'h00;
		next_role = 1'b0;
		case (state)
			ssi_pkg::ST_PASS:
			begin
				next_yellow = 1'b1;
				next_red = ssi_pkg::PASS_PATTERN;
				next_role = !boot_proc;
			end
			ssi_pkg::ST_FAIL:
			begin
				// Adapter failures leave yellow lit since the CPU itself passed.
				next_yellow = (fail_group_q == ssi_pkg::GRP_ADAPTER);
				next_red = code;
			end
			default:
			begin
				// Yellow stays dark until the sequence has completed.
				next_yellow = 1'b0;
			end
		endcase
		if (powerup)
		begin
			next_error = bus_error_status[ssi_pkg::BIT_ERR_SUMMARY];
		end
		else
		begin
			case (sel)
				ssi_pkg::SEL_SUMMARY: next_error = bus_error_status[ssi_pkg::BIT_ERR_SUMMARY];
				ssi_pkg::SEL_BCACHE: next_error = bcache_off;
				ssi_pkg::SEL_EITHER:
					next_error = bus_error_status[ssi_pkg::BIT_ERR_SUMMARY] || bcache_off;
				default: next_error = 1'b0;
			endcase
		end
		next_hit = in_node && (reg_rd || reg_wr) && (off == ssi_pkg::OFF_BUS_ERROR_STATUS
			|| off == ssi_pkg::OFF_GENERAL_SCRATCH
			|| off == ssi_pkg::OFF_PROCESSOR_CONTROL_ZERO);
		next_rdata = 32'h0000_0000;
		if (reg_rd && in_node)
		begin
			case (off)
				ssi_pkg::OFF_BUS_ERROR_STATUS: next_rdata = bus_error_status;
				ssi_pkg::OFF_GENERAL_SCRATCH: next_rdata = general_scratch;
				ssi_pkg::OFF_PROCESSOR_CONTROL_ZERO: next_rdata = processor_control_zero;
				default: next_rdata = 32'h0000_0000;
			endcase
		end
	end

	// Failing group is latched with the code so the yellow choice stays stable.
	always_comb
	begin
		next_fail_group_q = fail_group_q;
		if (state == ssi_pkg::ST_RUN && test_fail && shows_here)
		begin
			next_fail_group_q = fail_group;
		end
	end

	// All state registers.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state <= ssi_pkg::ST_RUN;
			bus_error_status <= ssi_pkg::RST_BUS_ERROR_STATUS;
			general_scratch <= ssi_pkg::RST_GENERAL_SCRATCH;
			processor_control_zero <= ssi_pkg::RST_PROCESSOR_CONTROL_ZERO;
			powerup <= 1'b1;
			code <= 8'h00;
			fail_group_q <= ssi_pkg::GRP_SELFTEST;
			led_yellow <= 1'b0;
			led_red <= 8'h00;
			led_role <= 1'b0;
			led_error <= 1'b0;
			reg_rdata <= 32'h0000_0000;
			reg_hit <= 1'b0;
		end
		else
		begin
			state <= next_state;
			bus_error_status <= next_bus_error_status;
			general_scratch <= next_general_scratch;
			processor_control_zero <= next_processor_control_zero;
			powerup <= next_powerup;
			code <= next_code;
			fail_group_q <= next_fail_group_q;
			led_yellow <= next_yellow;
			led_red <= next_red;
			led_role <= next_role;
			led_error <= next_error;
			reg_rdata <= next_rdata;
			reg_hit <= next_hit;
		end
	end

	// A pass shows the fixed pattern one cycle after the state is reached.
	a_pass_pattern: assert property (@(posedge clk) disable iff (rst)
		state == ssi_pkg::ST_PASS |=> led_yellow && led_red == 8'hc0)
		else $error("pass pattern wrong");
	// The role indicator tells a secondary from the boot processor.
	a_role_led: assert property (@(posedge clk) disable iff (rst)
		state == ssi_pkg::ST_PASS && $stable(boot_proc) |=> led_role == !$past(boot_proc))
		else $error("role indicator wrong");
	// A recorded failure is shown on the red column.
	a_fail_code: assert property (@(posedge clk) disable iff (rst)
		state == ssi_pkg::ST_FAIL |=> led_red == code)
		else $error("failing code not shown");
	// Yellow goes dark on every failure other than an adapter failure.
	a_fail_yellow: assert property (@(posedge clk) disable iff (rst)
		state == ssi_pkg::ST_FAIL && fail_group_q != ssi_pkg::GRP_ADAPTER |=> !led_yellow)
		else $error("yellow lit after failure");
	// Both digits of the held code stay decimal.
	a_bcd_digits: assert property (@(posedge clk) disable iff (rst)
		state == ssi_pkg::ST_FAIL |-> code[3:0] <= 4'h9 && code[7:4] <= 4'h9)
		else $error("code not bcd");
	// The scratch byte takes the code even when software writes in the same cycle.
	a_scratch_code: assert property (@(posedge clk) disable iff (rst)
		state == ssi_pkg::ST_RUN && test_fail && shows_here
		|=> general_scratch[31:24] == code)
		else $error("scratch code missing");
	// The on-board flag follows the group of the recorded failure.
	a_onboard_bit: assert property (@(posedge clk) disable iff (rst)
		state == ssi_pkg::ST_RUN && test_fail && shows_here
		|=> bus_error_status[10] == ($past(fail_group) == ssi_pkg::GRP_SELFTEST))
		else $error("onboard fail bit wrong");
	// A secondary never records an adapter failure.
	a_adapter_skip: assert property (@(posedge clk) disable iff (rst)
		state == ssi_pkg::ST_RUN && test_fail && !boot_proc
		&& fail_group == ssi_pkg::GRP_ADAPTER |=> state != ssi_pkg::ST_FAIL)
		else $error("adapter failure recorded on secondary");
	// The summary bit is set by its source whatever software writes.
	a_summary_sticky: assert property (@(posedge clk) disable iff (rst)
		error_summary_in |=> bus_error_status[31])
		else $error("error summary not set");
	// Reads outside this node give no hit and zero data.
	a_unmapped_read: assert property (@(posedge clk) disable iff (rst)
		reg_rd && !in_node |=> !reg_hit && reg_rdata == 32'h0000_0000)
		else $error("foreign read answered");
	// Selection code three keeps the error indicator dark.
	a_error_never: assert property (@(posedge clk) disable iff (rst)
		!powerup && sel == ssi_pkg::SEL_NEVER |=> !led_error)
		else $error("error led lit while disabled");
	// In power-up mode the error indicator follows the summary bit.
	a_powerup_err: assert property (@(posedge clk) disable iff (rst)
		powerup |=> led_error == $past(bus_error_status[31]))
		else $error("power-up error led wrong");
	// A finished sequence keeps its outcome until reset.
	a_hold_result: assert property (@(posedge clk) disable iff (rst)
		state != ssi_pkg::ST_RUN |=> state == $past(state) && $stable(code))
		else $error("result not held");
endmodule

// ### ssi_test_engine.sv
// Model of the self-test engine that reports one test sequence to the indicator.
module ssi_test_engine
(
	// Clock.
	input wire logic clk,
	// Request from the bench.
	input wire logic go,
	input wire logic fail,
	input wire logic [2:0] group,
	input wire logic [7:0] number,
	// Report towards the indicator.
	output logic test_done,
	output logic test_fail,
	output logic [2:0] fail_group,
	output logic [7:0] fail_number
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] phase = 2'h0;
	initial
	begin
		test_done = 1'b0;
		test_fail = 1'b0;
		fail_group = 3'h7;
		fail_number = 8'hff;
	end
	// Fail pulse, then done pulse; the qualifiers are inverted after the pulse.
	always @(posedge clk)
	begin
		test_fail <= 1'b0;
		test_done <= 1'b0;
		case (phase)
			2'h0:
			if (go)
			begin
				test_fail <= fail;
				fail_group <= group;
				fail_number <= number;
				phase <= 2'h1;
			end
			2'h1:
			begin
				fail_group <= ~fail_group;
				fail_number <= ~fail_number;
				test_done <= 1'b1;
				phase <= 2'h2;
			end
			default:
			if (!go)
				phase <= 2'h0;
		endcase
	end
endmodule

// ### testbench.sv
// Self-checking bench for the self-test status indicator.
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
	$display("[FAIL] %0t got %h want %h", $time, a, b); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic f; logic [2:0] g; logic [7:0] n; logic boot; logic [7:0] red;
		logic yel; logic b10;} ssi_row_t;
	ssi_row_t rows [8] = '{
		'{1, ssi_pkg::GRP_SELFTEST, 8'h20, 1, 8'h32, 0, 1},
		'{1, ssi_pkg::GRP_SELFTEST, 8'h39, 0, 8'h57, 0, 1},
		'{1, ssi_pkg::GRP_INTERACT, 8'h16, 1, 8'h82, 0, 0},
		'{1, ssi_pkg::GRP_MEMORY, 8'h02, 0, 8'h83, 0, 0},
		'{1, ssi_pkg::GRP_MEMORY, 8'h08, 1, 8'h89, 0, 0},
		'{1, ssi_pkg::GRP_MULTI, 8'h07, 0, 8'h97, 0, 0},
		'{1, ssi_pkg::GRP_ADAPTER, 8'h30, 1, 8'h48, 1, 0},
		'{0, ssi_pkg::GRP_SELFTEST, 8'h00, 1, 8'hc0, 1, 0}};
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] node_id = 4'h1;
	logic boot_proc = 1'b1;
	logic go = 1'b0;
	logic fail = 1'b0;
	logic [2:0] group = 3'h0;
	logic [7:0] number = 8'h00;
	logic test_done, test_fail, reg_hit, led_yellow, led_role, led_error, hit;
	logic [2:0] fail_group;
	logic [7:0] fail_number, led_red;
	logic error_summary_in = 1'b0;
	logic [31:0] reg_addr = 32'h0000_0000;
	logic reg_rd = 1'b0;
	logic reg_wr = 1'b0;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic [31:0] reg_rdata, d, base;
	int errors = 0;
	int n_tests = 0;
	ssi_test_engine eng (.clk(clk), .go(go), .fail(fail), .group(group), .number(number),
		.test_done(test_done), .test_fail(test_fail), .fail_group(fail_group),
		.fail_number(fail_number));
	ssi_selftest_status_indicator dut (.clk(clk), .rst(rst), .node_id(node_id),
		.boot_proc(boot_proc), .test_done(test_done), .test_fail(test_fail),
		.fail_group(fail_group), .fail_number(fail_number),
		.error_summary_in(error_summary_in), .reg_addr(reg_addr), .reg_rd(reg_rd),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
		.led_yellow(led_yellow), .led_red(led_red), .led_role(led_role),
		.led_error(led_error));
	// Free-running 50 MHz clock.
	initial
	begin
		forever #10 clk = ~clk;
	end
	// Closing report; one place decides the verdict.
	task print_verdict();
		$display("errors %0d n_tests %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Reset is held for five cycles, released at a falling edge.
	task rst_dut();
		rst = 1'b1;
		repeat (5) @(negedge clk);
		rst = 1'b0;
	endtask
	// One sequence through the engine model; the LEDs settle before return.
	task run(input logic f, input logic [2:0] g, input logic [7:0] n);
		@(negedge clk);
		go = 1'b1;
		fail = f;
		group = g;
		number = n;
		repeat (4) @(negedge clk);
		go = 1'b0;
		repeat (3) @(negedge clk);
	endtask
	// Register read; the answer stands exactly one cycle after the strobe edge.
	task rd(input logic [31:0] a);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		d = reg_rdata;
		hit = reg_hit;
	endtask
	task wr(input logic [31:0] a, input logic [31:0] v);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		repeat (2) @(negedge clk);
	endtask
	// A hung run is counted as a mismatch.
	initial
	begin
		#1000000;
		errors++;
		print_verdict();
	end
	initial
	begin
		// Ordinary outcomes, each on a different node address.
		foreach (rows[i])
		begin
			node_id = 4'(14 - i);
			boot_proc = rows[i].boot;
			base = ssi_pkg::NODE1_BASE + 32'(13 - i) * ssi_pkg::NODE_STRIDE;
			rst_dut();
			run(rows[i].f, rows[i].g, rows[i].n);
			`CHK(led_red, rows[i].red)
			`CHK(led_yellow, rows[i].yel)
			if (!rows[i].f)
				`CHK(led_role, 1'b0)
			rd(base + 32'(ssi_pkg::OFF_GENERAL_SCRATCH));
			// Scratch content is meaningless after a pass, so only failures compare it.
			if (rows[i].f)
				`CHK(d[31:24], rows[i].red)
			rd(base + 32'(ssi_pkg::OFF_BUS_ERROR_STATUS));
			`CHK({hit, d[10]}, {1'b1, rows[i].b10})
		end
		// Reset values, node 1 map and refused addresses.
		node_id = 4'h1;
		rst_dut();
		`CHK({led_yellow, led_red, led_role, led_error}, 11'h000)
		rd(32'he188_0024);
		`CHK({hit, d}, {1'b1, ssi_pkg::RST_PROCESSOR_CONTROL_ZERO})
		rd(32'he188_000c);
		`CHK({hit, d}, {1'b1, ssi_pkg::RST_GENERAL_SCRATCH})
		rd(32'he188_0008);
		`CHK({hit, d}, 33'h0)
		rd(32'he190_0004);
		`CHK(hit, 1'b0)
		// A later failure never overwrites the first; a scratch write leaves the LEDs.
		run(1'b1, ssi_pkg::GRP_SELFTEST, 8'h05);
		run(1'b1, ssi_pkg::GRP_MULTI, 8'h03);
		wr(32'he188_000c, 32'h0000_0000);
		`CHK(led_red, 8'h05)
		// Adapter failure on a secondary is dropped, leaving the pass pattern.
		boot_proc = 1'b0;
		rst_dut();
		run(1'b1, ssi_pkg::GRP_ADAPTER, 8'h01);
		`CHK({led_yellow, led_red, led_role}, {1'b1, 8'hc0, 1'b1})
		// Error LED: power-up summary mode, then the control selection codes.
		error_summary_in = 1'b1;
		repeat (3) @(negedge clk);
		error_summary_in = 1'b0;
		`CHK(led_error, 1'b1)
		rd(32'he188_0004);
		`CHK(d[31], 1'b1)
		wr(32'he188_0024, 32'h0000_6000);
		`CHK(led_error, 1'b0)
		wr(32'he188_0024, 32'h0000_2001);
		`CHK(led_error, 1'b1)
		wr(32'he188_0024, 32'h0000_2000);
		`CHK(led_error, 1'b0)
		wr(32'he188_0024, 32'h0000_4000);
		`CHK(led_error, 1'b1)
		// Selection code zero after power-up: the indicator follows the summary bit again.
		wr(32'he188_0024, 32'h0000_0000);
		`CHK(led_error, 1'b1)
		wr(32'he188_0004, 32'h0000_0000);
		`CHK(led_error, 1'b0)
		print_verdict();
	end
endmodule
